//--- hw/rbw_params.svh
/*
 Offsets, field positions, reset values, command codes and timing
 counts of the RAM back-up and wakeup sequencer.
 Assumes a 20 MHz system clock and a 32-bit APB register port.
*/
`ifndef RBW_PARAMS_SVH
`define RBW_PARAMS_SVH

// Register byte offsets
`define RBW_OFS_CTRL 8'h00
`define RBW_OFS_CMD 8'h04
`define RBW_OFS_STATUS 8'h08
`define RBW_OFS_FLAGS 8'h0C

// Control fields
`define RBW_CTRL_RST 17'h00000
`define RBW_CTRL_WAKE_LSB 0
`define RBW_CTRL_ICR_LSB 12
`define RBW_CTRL_EXTCLK_BIT 16
`define RBW_WAKE_P13_BIT 5

// Flag bits: undefined registers and events
`define RBW_FLG_Z 0
`define RBW_FLG_X 1
`define RBW_FLG_Y 2
`define RBW_FLG_D 3
`define RBW_FLG_E 4
`define RBW_FLG_EARLY 5
`define RBW_FLG_SEQERR 6
`define RBW_FLAGS_RST 7'h19

// Command codes
`define RBW_CMD_OTHER 4'h0
`define RBW_CMD_ARM 4'h1
`define RBW_CMD_HOLD 4'h2
`define RBW_CMD_IMASK 4'h3
`define RBW_CMD_IUNMASK 4'h4
`define RBW_CMD_WDSTOP 4'h5
`define RBW_CMD_WDRST 4'h6
`define RBW_CMD_CERSEL 4'h7
`define RBW_CMD_RCSEL 4'h8

// Timing
`define RBW_CLK_NS 50
`define RBW_MCYC_NS 150
`define RBW_MCYC_CLKS ((`RBW_MCYC_NS + `RBW_CLK_NS - 1) / `RBW_CLK_NS)
`define RBW_STAB_TICKS 16

`endif

//--- hw/rbw_pkg.sv
/*
 Types of the RAM back-up and wakeup sequencer.
 Assumes rbw_params.svh is on the include path.
*/
`include "rbw_params.svh"

package rbw_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		RBW_ST_WAIT = 4'h1,
		RBW_ST_RUN = 4'h2,
		RBW_ST_ARMED = 4'h4,
		RBW_ST_BACKUP = 4'h8
	} rbw_state_t;

	// Oscillator choice
	typedef enum logic [1:0] {
		RBW_OSC_NONE = 2'h0,
		RBW_OSC_CER = 2'h1,
		RBW_OSC_RC = 2'h2
	} rbw_osc_t;

endpackage

//--- hw/rbw_sync3.sv
/*
 Three-flop input synchroniser with agreement filter.
 Assumes inputs come from pins outside the clk_sys domain.
*/
`timescale 1ns/1ps

module rbw_sync3 import rbw_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;
	wire [W-1:0] agree = ~(s2_q ^ s3_q);

	// Shift chain; output follows where stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end
		else if (ce)
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= (agree & s3_q) | (~agree & out_q);
		end
	end

	assign dout = out_q;

endmodule

//--- hw/rbw_stab_wait.sv
/*
 Oscillation-stabilise wait counter, stepped by on-chip oscillator
 ticks. Assumes tick is a one-cycle pulse in the clk_sys domain.
*/
`timescale 1ns/1ps

module rbw_stab_wait import rbw_pkg::*; #(
	parameter int TICKS = `RBW_STAB_TICKS,
	parameter int CW = $clog2(TICKS + 1)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic restart,
	input wire logic tick,
	output logic done
);

	localparam logic [CW-1:0] LAST = CW'(TICKS);
	logic [CW-1:0] cnt_q;
	wire at_end = (cnt_q == LAST);

	// Counts oscillator ticks, not system clocks
	always_ff @(posedge clk_sys)
	begin
		if (rst || (ce && restart))
			cnt_q <= '0;
		else if (ce && tick && !at_end)
			cnt_q <= cnt_q + CW'(1);
	end

	assign done = at_end;

endmodule

//--- hw/rbw_seq.sv
/*
 RAM back-up entry and exit sequencer with key-on wakeup,
 oscillator select and watchdog re-enable, on an APB register port.
 Assumes software issues instructions as writes to the command
 register, wakeup pins and the reset pin are asynchronous, and the
 on-chip oscillator arrives as a slow square wave.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps

module rbw_seq import rbw_pkg::*; #(
	parameter int NWAKE = 12,
	parameter int STAB_TICKS = `RBW_STAB_TICKS,
	parameter int MCYC_CLKS = `RBW_MCYC_CLKS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NWAKE-1:0] wake_pins,
	input wire logic ext_reset_n,
	input wire logic onchip_osc,
	output logic backup_q,
	output logic cpu_hold_q,
	output logic osc_cer_en_q,
	output logic osc_rc_en_q,
	output logic osc_onchip_en_q,
	output logic wdt_en_q,
	output logic int_pin_en_q
);

	localparam int FW = 7;

	// Filtered pins
	logic [NWAKE-1:0] wake_f;
	logic ext_rst_f;
	logic osc_f;

	rbw_sync3 #(.W(NWAKE), .INIT('1)) u_wake_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.din(wake_pins),
		.dout(wake_f)
	);

	rbw_sync3 #(.W(2), .INIT(2'h3)) u_misc_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.din({ext_reset_n, onchip_osc}),
		.dout({ext_rst_f, osc_f})
	);

	// Registers
	rbw_state_t state_q;
	rbw_state_t state_d;
	rbw_osc_t osc_q;
	rbw_osc_t osc_d;
	logic [16:0] ctrl_q;
	logic [FW-1:0] flags_q;
	logic [FW-1:0] flags_set;
	logic int_en_q;
	logic int_en_d;
	logic wd_stop_q;
	logic wd_stop_d;
	logic wdt_d;
	logic osc_prev_q;
	logic [7:0] rlow_q;
	logic rst_hit;
	logic [31:0] rdata_d;
	logic rerr_d;

	// APB decode; a transfer completes one cycle into the access phase
	wire access = psel && penable;
	wire done_xfer = access && pready;
	wire wr_ok = done_xfer && pwrite;
	wire hit_ctrl = (paddr == `RBW_OFS_CTRL);
	wire hit_cmd = (paddr == `RBW_OFS_CMD);
	wire hit_stat = (paddr == `RBW_OFS_STATUS);
	wire hit_flg = (paddr == `RBW_OFS_FLAGS);
	wire mapped = hit_ctrl | hit_cmd | hit_stat | hit_flg;
	wire cmd_go = wr_ok && hit_cmd;
	wire [3:0] cmd = pwdata[3:0];
	wire [FW-1:0] flags_clr = (wr_ok && hit_flg) ? pwdata[FW-1:0] : '0;

	// Control fields
	wire [NWAKE-1:0] wake_en = ctrl_q[`RBW_CTRL_WAKE_LSB +: NWAKE];
	wire [3:0] icr1 = ctrl_q[`RBW_CTRL_ICR_LSB +: 4];
	wire ext_clk = ctrl_q[`RBW_CTRL_EXTCLK_BIT];

	// Wakeup condition: any enabled pin low
	wire any_low = |(wake_en & ~wake_f);

	// Entry checks at the hold step
	wire bad_p13 = !wake_en[`RBW_WAKE_P13_BIT] && (icr1[3:2] != 2'h0);
	wire bad_icr = icr1[3];
	wire refuse = int_en_q || ext_clk || bad_p13 || bad_icr;

	// On-chip oscillator rising edge, taken from the filtered copy
	wire osc_tick = osc_f && !osc_prev_q;
	wire stab_done;

	rbw_stab_wait #(.TICKS(STAB_TICKS)) u_stab (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.restart(rst_hit),
		.tick(osc_tick),
		.done(stab_done)
	);

	// Long external reset only; short glitches are ignored
	assign rst_hit = (rlow_q >= 8'(MCYC_CLKS));

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rlow_q <= 8'h00;
		else if (ce)
		begin
			if (ext_rst_f)
				rlow_q <= 8'h00;
			else if (!rst_hit)
				rlow_q <= rlow_q + 8'h01;
		end
	end

	// Sequencer next state and side effects
	always_comb
	begin
		state_d = state_q;
		osc_d = osc_q;
		int_en_d = int_en_q;
		wd_stop_d = wd_stop_q;
		wdt_d = wdt_en_q;
		flags_set = '0;
		if (cmd_go)
			wd_stop_d = (cmd == `RBW_CMD_WDSTOP);
		case (state_q)
			RBW_ST_WAIT:
			begin
				if (stab_done)
					state_d = RBW_ST_RUN;
			end
			RBW_ST_RUN, RBW_ST_ARMED:
			begin
				if (cmd_go)
				begin
					state_d = RBW_ST_RUN;
					case (cmd)
						`RBW_CMD_ARM:
							state_d = RBW_ST_ARMED;
						`RBW_CMD_HOLD:
						begin
							if (state_q != RBW_ST_ARMED)
								state_d = RBW_ST_RUN;
							else if (refuse)
								flags_set[`RBW_FLG_SEQERR] = 1'b1;
							else if (any_low)
							begin
								flags_set = 7'h3F;
								wdt_d = 1'b1;
							end
							else
								state_d = RBW_ST_BACKUP;
						end
						`RBW_CMD_IMASK:
							int_en_d = 1'b0;
						`RBW_CMD_IUNMASK:
							int_en_d = 1'b1;
						`RBW_CMD_WDRST:
						begin
							if (wd_stop_q)
								wdt_d = 1'b0;
						end
						`RBW_CMD_CERSEL:
						begin
							if (osc_q == RBW_OSC_NONE)
								osc_d = RBW_OSC_CER;
						end
						`RBW_CMD_RCSEL:
						begin
							if (osc_q == RBW_OSC_NONE)
								osc_d = RBW_OSC_RC;
						end
						default:
							state_d = RBW_ST_RUN;
					endcase
				end
			end
			RBW_ST_BACKUP:
			begin
				if (any_low)
				begin
					state_d = RBW_ST_RUN;
					flags_set[`RBW_FLG_E:`RBW_FLG_Z] = 5'h1F;
					wdt_d = 1'b1;
				end
			end
			default:
				state_d = RBW_ST_WAIT;
		endcase
		if (rst_hit)
		begin
			state_d = RBW_ST_WAIT;
			osc_d = RBW_OSC_NONE;
			int_en_d = 1'b0;
			wd_stop_d = 1'b0;
			wdt_d = 1'b1;
			flags_set = '0;
			flags_set[`RBW_FLG_Z] = 1'b1;
			flags_set[`RBW_FLG_D] = 1'b1;
			flags_set[`RBW_FLG_E] = 1'b1;
		end
	end

	// Sequencer state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= RBW_ST_WAIT;
			osc_q <= RBW_OSC_NONE;
			int_en_q <= 1'b0;
			wd_stop_q <= 1'b0;
			wdt_en_q <= 1'b1;
			osc_prev_q <= 1'b1;
		end
		else if (ce)
		begin
			state_q <= state_d;
			osc_q <= osc_d;
			int_en_q <= int_en_d;
			wd_stop_q <= wd_stop_d;
			wdt_en_q <= wdt_d;
			osc_prev_q <= osc_f;
		end
	end

	// Flags: set wins over software clear
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			flags_q <= `RBW_FLAGS_RST;
		else if (ce)
			flags_q <= (flags_q & ~flags_clr) | flags_set;
	end

	// Control register
	always_ff @(posedge clk_sys)
	begin
		if (rst || (ce && rst_hit))
			ctrl_q <= `RBW_CTRL_RST;
		else if (ce && wr_ok && hit_ctrl)
			ctrl_q <= pwdata[16:0];
	end

	// Pin-facing outputs, all registered
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			backup_q <= 1'b0;
			cpu_hold_q <= 1'b1;
			osc_cer_en_q <= 1'b1;
			osc_rc_en_q <= 1'b1;
			osc_onchip_en_q <= 1'b1;
			int_pin_en_q <= 1'b0;
		end
		else if (ce)
		begin
			backup_q <= (state_d == RBW_ST_BACKUP);
			cpu_hold_q <= (state_d == RBW_ST_WAIT);
			osc_cer_en_q <= (osc_d != RBW_OSC_RC);
			osc_rc_en_q <= (osc_d != RBW_OSC_CER);
			osc_onchip_en_q <= (osc_d == RBW_OSC_NONE);
			int_pin_en_q <= rst_hit ? 1'b0 : icr1[3];
		end
	end

	// Read mux
	always_comb
	begin
		rdata_d = 32'h00000000;
		rerr_d = !mapped || (pwrite && hit_stat);
		if (hit_ctrl)
			rdata_d[16:0] = ctrl_q;
		else if (hit_stat)
			rdata_d[11:0] = {wake_f[3:0], int_en_q, wdt_en_q,
				osc_q, state_q};
		else if (hit_flg)
			rdata_d[FW-1:0] = flags_q;
	end

	// APB answer: ready one cycle into the access phase
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else if (ce)
		begin
			pready_q <= access && !pready_q;
			pslverr_q <= access && !pready_q && rerr_d;
			prdata_q <= (access && !pready_q && !pwrite) ? rdata_d
				: 32'h00000000;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

endmodule

//--- sim/rbw_seq_checker.sv
/*
 Port checker of the back-up sequencer, bound to rbw_seq.
 Assumes instructions arrive as APB writes to the command register.
*/
`timescale 1ns/1ps
`include "rbw_params.svh"

module rbw_seq_checker import rbw_pkg::*; #(
	parameter int NWAKE = 12,
	parameter int STAB_TICKS = `RBW_STAB_TICKS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [NWAKE-1:0] wake_pins,
	input wire logic onchip_osc,
	input wire logic backup_q,
	input wire logic cpu_hold_q,
	input wire logic osc_cer_en_q,
	input wire logic osc_rc_en_q,
	input wire logic osc_onchip_en_q,
	input wire logic wdt_en_q,
	input wire logic int_pin_en_q
);
	logic [16:0] ctrl_q;
	logic [3:0] last_q;
	logic int_q;
	logic osc_q;
	logic [7:0] tick_q;
	// Decode of committed writes
	wire wr_w = psel && penable && pready && pwrite;
	wire ctrl_w = wr_w && paddr == `RBW_OFS_CTRL;
	wire cmd_w = wr_w && paddr == `RBW_OFS_CMD;
	wire hold_w = cmd_w && pwdata[3:0] == `RBW_CMD_HOLD;
	wire hold_ok_w = hold_w && last_q == `RBW_CMD_ARM;
	wire wdrst_w = cmd_w && pwdata[3:0] == `RBW_CMD_WDRST;
	wire p13_w = ctrl_q[`RBW_WAKE_P13_BIT];
	wire bad_w = ctrl_q[16] || ctrl_q[15] || int_q || (!p13_w && ctrl_q[14]);
	wire key_w = |(~wake_pins & ctrl_q[NWAKE-1:0]);
	// Shadow of control, last command, mask and oscillator ticks
	always_ff @(posedge clk_sys)
	begin
		osc_q <= onchip_osc;
		if (rst || !cpu_hold_q)
			tick_q <= 8'h00;
		else if (onchip_osc && !osc_q && tick_q != 8'hFF)
			tick_q <= tick_q + 8'h01;
		if (rst)
		begin
			ctrl_q <= 17'h00000;
			last_q <= 4'h0;
			int_q <= 1'b0;
		end
		else
		begin
			if (ctrl_w)
				ctrl_q <= pwdata[16:0];
			if (cmd_w)
				last_q <= pwdata[3:0];
			if (cmd_w && pwdata[3:0] == `RBW_CMD_IUNMASK)
				int_q <= 1'b1;
			else if (cmd_w && pwdata[3:0] == `RBW_CMD_IMASK)
				int_q <= 1'b0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Three cycles after a hold with no entry
	sequence s_no_entry;
		##1 !backup_q [*3];
	endsequence
	entry_needs_arm_a: assert property ($rose(backup_q) |->
		$past(hold_ok_w) || $past(hold_ok_w, 2)) else $error("entry w/o arm");
	entry_refused_a: assert property (hold_ok_w && bad_w |-> s_no_entry)
		else $error("entry not refused");
	early_return_a: assert property (hold_w && key_w |-> s_no_entry)
		else $error("entry with key low");
	wake_wdt_a: assert property ($fell(backup_q) |-> ##[0:1] wdt_en_q)
		else $error("watchdog off after return");
	wdt_stop_a: assert property ($fell(wdt_en_q) |->
		$past(wdrst_w) || $past(wdrst_w, 2)) else $error("watchdog stop");
	int_pin_a: assert property (ctrl_w |-> ##2 int_pin_en_q == ctrl_q[15])
		else $error("pin enable copy");
	osc_stop_a: assert property (osc_onchip_en_q == (osc_cer_en_q && osc_rc_en_q))
		else $error("oscillator enables");
	osc_once_a: assert property (!osc_onchip_en_q |=> osc_onchip_en_q ||
		$stable({osc_cer_en_q, osc_rc_en_q})) else $error("oscillator changed");
	// One filtered edge may still be in flight at a restart
	stab_wait_a: assert property ($fell(cpu_hold_q) |-> tick_q + 8'h01 >= STAB_TICKS)
		else $error("wait too short");
endmodule

bind rbw_seq rbw_seq_checker #(.NWAKE(NWAKE), .STAB_TICKS(STAB_TICKS))
	rbw_seq_checker_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .wake_pins(wake_pins), .onchip_osc(onchip_osc),
	.backup_q(backup_q), .cpu_hold_q(cpu_hold_q),
	.osc_cer_en_q(osc_cer_en_q), .osc_rc_en_q(osc_rc_en_q),
	.osc_onchip_en_q(osc_onchip_en_q), .wdt_en_q(wdt_en_q),
	.int_pin_en_q(int_pin_en_q));

//--- sim/rbw_pin_model.sv
/*
 Far side: key pins, external reset source, on-chip oscillator.
 Assumes the bench asks for key presses and reset pulses.
*/
`timescale 1ns/1ps

module rbw_pin_model import rbw_pkg::*; #(
	parameter int NWAKE = 12,
	parameter int LOW_CLKS = 8
) (
	input wire logic clk_sys,
	input wire logic [NWAKE-1:0] key_low,
	input wire logic reset_req,
	output logic [NWAKE-1:0] wake_pins,
	output logic ext_reset_n,
	output logic onchip_osc
);
	logic [3:0] low_q = 4'h0;
	logic [2:0] div_q = 3'h0;
	// Released keys go to the pull-up level
	assign wake_pins = ~key_low;
	assign ext_reset_n = (low_q == 4'h0);
	assign onchip_osc = ~div_q[2];
	// Reset pulse well over one machine cycle, slow oscillator
	always_ff @(posedge clk_sys)
	begin
		div_q <= div_q + 3'h1;
		if (reset_req)
			low_q <= 4'(LOW_CLKS);
		else if (low_q != 4'h0)
			low_q <= low_q - 4'h1;
	end
endmodule

//--- sim/rbw_seq_tb_top.sv
/*
 Self-checking bench of the back-up sequencer over APB.
 Assumes the bound checker and the pin model beside the design.
*/
`timescale 1ns/1ps
`include "rbw_params.svh"

module rbw_seq_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [11:0] key_low = 12'h000;
	logic reset_req = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rd_q;
	logic [11:0] wake_pins;
	logic pready, pslverr, se_q, ext_reset_n, onchip_osc;
	logic backup_q, cpu_hold_q, wdt_en_q, int_pin_en_q;
	logic osc_cer_en_q, osc_rc_en_q, osc_onchip_en_q;
	logic [16:0] bad_ctrl [4] = '{17'h10000, 17'h04000, 17'h08000, 17'h0};
	logic [3:0] bad_pre [4] = '{4'h3, 4'h3, 4'h3, 4'h4};
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	wire [6:0] outs_w = {backup_q, cpu_hold_q, osc_cer_en_q, osc_rc_en_q,
		osc_onchip_en_q, wdt_en_q, int_pin_en_q};

	rbw_seq #(.NWAKE(12), .STAB_TICKS(2)) rbw_seq_inst (.clk_sys(clk_sys),
		.rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_pins(wake_pins),
		.ext_reset_n(ext_reset_n), .onchip_osc(onchip_osc),
		.backup_q(backup_q), .cpu_hold_q(cpu_hold_q),
		.osc_cer_en_q(osc_cer_en_q), .osc_rc_en_q(osc_rc_en_q),
		.osc_onchip_en_q(osc_onchip_en_q), .wdt_en_q(wdt_en_q),
		.int_pin_en_q(int_pin_en_q));
	rbw_pin_model rbw_pin_model_inst (.clk_sys(clk_sys), .key_low(key_low),
		.reset_req(reset_req), .wake_pins(wake_pins),
		.ext_reset_n(ext_reset_n), .onchip_osc(onchip_osc));

	always #25 clk_sys = ~clk_sys;

	task automatic close_out;
		$display("Checks %0d, errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer, released after pready is seen or, with an error counted, after 21 cycles without it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1 && k++ < 20);
		if (k >= 20)
			err_total++;
		rd_q = prdata;
		se_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic cmd(input logic [3:0] c);
		apb(1'b1, `RBW_OFS_CMD, {28'h0000000, c});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rd_q & m, e);
	endtask

	task automatic chk_out(input logic [6:0] e);
		repeat (2) @(posedge clk_sys);
		chk({25'h0000000, outs_w}, {25'h0000000, e});
	endtask

	// Bounded wait for back-up (sel 1) or hold (sel 0) to reach v
	task automatic wait_sig(input int sel, input logic v);
		n = 0;
		while ((sel == 1 ? backup_q : cpu_hold_q) !== v && n < 400)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 400)
			err_total++;
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			close_out;
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_sys);
		chk_out(7'h3E);
		rst <= 1'b0;
		wait_sig(0, 1'b0);
		chk({31'h0, n >= 8}, 32'h1);
		rd(`RBW_OFS_FLAGS, 32'h7F, 32'h19);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, se_q}, 32'h1);
		apb(1'b1, `RBW_OFS_STATUS, 32'h0);
		chk({31'h0, se_q}, 32'h1);
		apb(1'b1, `RBW_OFS_FLAGS, 32'h7F);
		cmd(`RBW_CMD_RCSEL);
		cmd(`RBW_CMD_CERSEL);
		rd(`RBW_OFS_STATUS, 32'h3F, 32'h22);
		chk_out(7'h0A);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, `RBW_OFS_CTRL, {15'h0, bad_ctrl[i]});
			cmd(bad_pre[i]);
			cmd(`RBW_CMD_ARM);
			cmd(`RBW_CMD_HOLD);
			chk_out({6'h05, bad_ctrl[i][15]});
			rd(`RBW_OFS_FLAGS, 32'h7F, 32'h40);
			apb(1'b1, `RBW_OFS_FLAGS, 32'h40);
			cmd(`RBW_CMD_IMASK);
		end
		cmd(`RBW_CMD_HOLD);
		rd(`RBW_OFS_STATUS, 32'hF, 32'h2);
		cmd(`RBW_CMD_ARM);
		rd(`RBW_OFS_STATUS, 32'hF, 32'h4);
		cmd(`RBW_CMD_OTHER);
		cmd(`RBW_CMD_HOLD);
		rd(`RBW_OFS_STATUS, 32'hF, 32'h2);
		key_low <= 12'h001;
		apb(1'b1, `RBW_OFS_CTRL, 32'h21);
		cmd(`RBW_CMD_WDSTOP);
		cmd(`RBW_CMD_WDRST);
		chk_out(7'h08);
		cmd(`RBW_CMD_ARM);
		cmd(`RBW_CMD_HOLD);
		rd(`RBW_OFS_FLAGS, 32'h7F, 32'h3F);
		chk_out(7'h0A);
		key_low <= 12'h000;
		apb(1'b1, `RBW_OFS_FLAGS, 32'h7F);
		cmd(`RBW_CMD_WDSTOP);
		cmd(`RBW_CMD_OTHER);
		cmd(`RBW_CMD_WDRST);
		chk_out(7'h0A);
		cmd(`RBW_CMD_WDSTOP);
		cmd(`RBW_CMD_WDRST);
		cmd(`RBW_CMD_ARM);
		cmd(`RBW_CMD_HOLD);
		chk_out(7'h48);
		ce <= 1'b0;
		key_low <= 12'h020;
		repeat (6) @(posedge clk_sys);
		chk_out(7'h48);
		ce <= 1'b1;
		wait_sig(1, 1'b0);
		chk_out(7'h0A);
		key_low <= 12'h000;
		rd(`RBW_OFS_FLAGS, 32'h7F, 32'h1F);
		apb(1'b1, `RBW_OFS_FLAGS, 32'h7F);
		reset_req <= 1'b1;
		@(posedge clk_sys);
		reset_req <= 1'b0;
		wait_sig(0, 1'b1);
		wait_sig(0, 1'b0);
		rd(`RBW_OFS_FLAGS, 32'h7F, 32'h19);
		rd(`RBW_OFS_CTRL, 32'h1FFFF, 32'h0);
		chk_out(7'h1E);
		close_out;
	end
endmodule
